//--- rtl/nic_host_slave_port.sv
`timescale 1ns/10ps
// Functional notes
// - the interrupt output is raised when reception, transmission or a dma transfer needs service.
// - writing the event status register with ones clears those pending events and their request.
// - each event source has its own mask bit, and a masked source never drives the interrupt.
// - on the latch write acknowledge the block runs a local memory write of the latched data.
// - during that write the latch output enable drives the latch contents onto the local bus.
// - the four-bit register select chooses which internal register is read or written.
// - register select is ignored while chip select is high.
// - chip select low with dma idle places the block in slave mode, which is not held and ends as soon as either changes.
// - with dma idle and chip select low, select is latched on the strobe's fall and flows while high.
// - slave register data uses the low eight bus lines and the upper eight float.
module nic_host_slave_port
	import nic_host_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYC
)
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// internal events
	input wire logic rx_done_i,
	input wire logic tx_done_i,
	input wire logic dma_done_i,
	input wire logic dma_active_i,
	// remote write
	input wire logic [15:0] remote_addr_i,
	input wire logic latch_write_ack_i,
	output logic latch_output_enable_b_o,
	output logic mem_write_b_o,
	output logic remote_write_done_o,
	// host slave bus
	input wire logic chip_select_b_i,
	input wire logic addr_latch_strobe_i,
	input wire logic [3:0] reg_select_i,
	input wire logic slave_read_strobe_b_i,
	input wire logic slave_write_strobe_b_i,
	input wire logic [15:0] muxed_addr_data_i,
	output logic [15:0] muxed_addr_data_o,
	output logic [15:0] muxed_addr_data_oe_b_o,
	// interrupt
	output logic irq_o
);
	nic_evt_if ev ();
	logic [3:0] sel_latch;
	logic [3:0] reg_sel;
	logic strobe_d;
	logic slave_mode;
	logic wr_d;
	logic [7:0] rd_data;
	logic [15:0] bus_out;
	logic [15:0] bus_oe_b;
	rw_state_type rw_state;
	rw_state_type next_rw_state;
	logic [3:0] rw_cnt;
	logic ack_d;
	logic rw_busy;

	assign slave_mode = !chip_select_b_i && !dma_active_i;

	// slave reads are refused while a remote write owns the bus
	assign rw_busy = (rw_state != RW_IDLE);

	nic_event_ctl u_event_ctl (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.ev(ev)
	);

	// event inputs
	assign ev.evt[EVT_RX_POS] = rx_done_i;
	assign ev.evt[EVT_TX_POS] = tx_done_i;
	assign ev.evt[EVT_DMA_POS] = dma_done_i;

	// select latch: capture on strobe fall, flow while high
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			strobe_d <= 1'b0;
		else
			strobe_d <= addr_latch_strobe_i;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sel_latch <= SEL_RESET;
		else if (slave_mode && strobe_d && !addr_latch_strobe_i)
			sel_latch <= reg_select_i;
	end

	// transparent while strobe high, held once it falls
	assign reg_sel = (slave_mode && addr_latch_strobe_i) ? reg_select_i : sel_latch;

	// write access on falling edge of strobe (registered)
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			wr_d <= 1'b0;
		else
			wr_d <= slave_mode && !slave_write_strobe_b_i;
	end

	logic wr_pulse;
	assign wr_pulse = slave_mode && !slave_write_strobe_b_i && !wr_d;

	assign ev.clr = (wr_pulse && reg_sel == STATUS_SEL) ? muxed_addr_data_i[2:0] : EVT_RESET;
	assign ev.mask_we = wr_pulse && reg_sel == MASK_SEL;
	assign ev.mask_wdata = muxed_addr_data_i[2:0];

	always_comb
	begin
		rd_data = DATA_RESET;
		case (reg_sel)
			STATUS_SEL: rd_data = {5'h00, ev.status};
			MASK_SEL: rd_data = {5'h00, ev.mask};
			default: rd_data = DATA_RESET;
		endcase
	end

	// remote write sequencer
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			ack_d <= 1'b0;
		else
			ack_d <= latch_write_ack_i;
	end

	always_comb
	begin
		next_rw_state = rw_state;
		case (rw_state)
			RW_IDLE:
			begin
				if (latch_write_ack_i && !ack_d)
					next_rw_state = RW_ADDR;
			end
			RW_ADDR: next_rw_state = RW_DATA;
			RW_DATA:
			begin
				if (rw_cnt == 4'(WRITE_CYCLES - 1))
					next_rw_state = RW_DONE;
			end
			RW_DONE: next_rw_state = RW_IDLE;
			default: next_rw_state = RW_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rw_state <= RW_IDLE;
		else
			rw_state <= next_rw_state;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rw_cnt <= CNT_RESET;
		else if (rw_state == RW_DATA)
			rw_cnt <= rw_cnt + 4'h1;
		else
			rw_cnt <= CNT_RESET;
	end

	// output registers
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			latch_output_enable_b_o <= 1'b1;
		else
			latch_output_enable_b_o <= !(next_rw_state == RW_DATA);
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mem_write_b_o <= 1'b1;
		else
			mem_write_b_o <= !(next_rw_state == RW_DATA);
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			remote_write_done_o <= 1'b0;
		else
			remote_write_done_o <= (rw_state == RW_DONE);
	end

	// bus drive: address phase for remote write, low byte for slave reads
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bus_out <= ADDR_RESET;
			bus_oe_b <= 16'hffff;
		end
		else if (next_rw_state == RW_ADDR)
		begin
			bus_out <= remote_addr_i;
			bus_oe_b <= 16'h0000;
		end
		else if (slave_mode && !slave_read_strobe_b_i && !rw_busy)
		begin
			bus_out <= {8'h00, rd_data};
			bus_oe_b <= 16'hff00;
		end
		else
		begin
			bus_out <= ADDR_RESET;
			bus_oe_b <= 16'hffff;
		end
	end

	assign muxed_addr_data_o = bus_out;
	assign muxed_addr_data_oe_b_o = bus_oe_b;
	assign irq_o = ev.irq;
endmodule : nic_host_slave_port

//--- rtl/nic_host_pkg.sv
package nic_host_pkg;
	// event bit positions
	localparam int EVT_RX_POS = 0;
	localparam int EVT_TX_POS = 1;
	localparam int EVT_DMA_POS = 2;
	localparam int EVT_W = 3;
	localparam logic [2:0] EVT_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	// register select
	localparam int SEL_W = 4;
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic [3:0] STATUS_SEL = 4'h7;
	localparam logic [3:0] MASK_SEL = 4'hf;
	// bus widths
	localparam int BUS_W = 16;
	localparam int DATA_W = 8;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	// remote write timing
	localparam int WRITE_NS = 20;
	localparam int CLK_NS = 5;
	localparam int WRITE_CYC = (WRITE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] CNT_RESET = 4'h0;
	typedef enum logic [1:0] {
		RW_IDLE = 2'b00,
		RW_ADDR = 2'b01,
		RW_DATA = 2'b11,
		RW_DONE = 2'b10
	} rw_state_type;
endpackage : nic_host_pkg

//--- rtl/nic_evt_if.sv
`timescale 1ns/10ps
interface nic_evt_if;
	logic [2:0] evt;
	logic [2:0] status;
	logic [2:0] mask;
	logic [2:0] clr;
	logic mask_we;
	logic [2:0] mask_wdata;
	logic irq;
	modport ctl (input evt, input clr, input mask_we, input mask_wdata, output status, output mask, output irq);
	modport top (output evt, output clr, output mask_we, output mask_wdata, input status, input mask, input irq);
endinterface : nic_evt_if

//--- rtl/nic_event_ctl.sv
`timescale 1ns/10ps
module nic_event_ctl
	import nic_host_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// event port
	nic_evt_if.ctl ev
);
	logic [2:0] status;
	logic [2:0] mask;

	// set wins over clear
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			status <= EVT_RESET;
		else
			status <= (status & ~ev.clr) | ev.evt;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mask <= MASK_RESET;
		else if (ev.mask_we)
			mask <= ev.mask_wdata;
	end

	assign ev.status = status;
	assign ev.mask = mask;
	assign ev.irq = |(status & mask);
endmodule : nic_event_ctl

//--- dv/nic_latch_host.sv
`timescale 1ns/10ps
module nic_latch_host
(
	// clock, reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// bench and device
	input wire logic go_i,
	input wire logic [3:0] load_i,
	input wire logic done_i,
	output logic ack_o
);
	logic [3:0] cnt;
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cnt <= 4'h0;
		else if (go_i)
			cnt <= load_i + 4'h1;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	// ack only once the latch load time has run out; held until the write ends
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			ack_o <= 1'b0;
		else if (done_i)
			ack_o <= 1'b0;
		else if (cnt == 4'h1 && !go_i)
			ack_o <= 1'b1;
	end
endmodule : nic_latch_host

//--- dv/nic_host_slave_port_sva.sv
`timescale 1ns/10ps
module nic_host_slave_port_sva
	import nic_host_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYC
)
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic rx_done_i,
	input wire logic tx_done_i,
	input wire logic dma_done_i,
	input wire logic latch_write_ack_i,
	input wire logic chip_select_b_i,
	input wire logic slave_write_strobe_b_i,
	input logic latch_output_enable_b_o,
	input logic mem_write_b_o,
	input logic remote_write_done_o,
	input logic [15:0] muxed_addr_data_oe_b_o,
	input logic irq_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_write_len: assert property ($fell(latch_output_enable_b_o) |-> latch_output_enable_b_o == 1'b0 [*4]
		##1 latch_output_enable_b_o) else $error("write width");
	a_strobe_pair: assert property (mem_write_b_o == latch_output_enable_b_o) else $error("strobes");
	a_bus_float: assert property (!latch_output_enable_b_o |-> &muxed_addr_data_oe_b_o) else $error("bus");
	a_done_after: assert property ($rose(latch_output_enable_b_o) |-> ##[0:2] remote_write_done_o)
		else $error("done");
	a_upper_float: assert property (!muxed_addr_data_oe_b_o[0] && !latch_write_ack_i
		|-> &muxed_addr_data_oe_b_o[15:8]) else $error("upper");
	a_cs_gate: assert property (chip_select_b_i && $past(chip_select_b_i) && !latch_write_ack_i
		|=> &muxed_addr_data_oe_b_o[7:0]) else $error("cs");
	a_irq_hold: assert property (!rx_done_i && !tx_done_i && !dma_done_i && slave_write_strobe_b_i
		|=> $stable(irq_o)) else $error("irq hold");
	a_irq_cause: assert property ($rose(irq_o) |-> $past(rx_done_i || tx_done_i || dma_done_i
		|| !slave_write_strobe_b_i)) else $error("irq cause");
	cover property ($fell(latch_output_enable_b_o));
	cover property ($rose(irq_o));
	cover property ($fell(slave_write_strobe_b_i) && !chip_select_b_i);
endmodule : nic_host_slave_port_sva
bind nic_host_slave_port nic_host_slave_port_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (
	.core_clk_i(core_clk_i),
	.rst_b_i(rst_b_i),
	.rx_done_i(rx_done_i),
	.tx_done_i(tx_done_i),
	.dma_done_i(dma_done_i),
	.latch_write_ack_i(latch_write_ack_i),
	.chip_select_b_i(chip_select_b_i),
	.slave_write_strobe_b_i(slave_write_strobe_b_i),
	.latch_output_enable_b_o(latch_output_enable_b_o),
	.mem_write_b_o(mem_write_b_o),
	.remote_write_done_o(remote_write_done_o),
	.muxed_addr_data_oe_b_o(muxed_addr_data_oe_b_o),
	.irq_o(irq_o)
);

//--- dv/nic_host_slave_port_tb_top.sv
`timescale 1ns/10ps
module nic_host_slave_port_tb_top;
	import nic_host_pkg::*;
	logic [6:0] rows [5] = '{7'h13, 7'h25, 7'h49, 7'h70, 7'h54};
	logic clk = 0, rst_b = 0, cs_b = 1, as = 1, rd_b = 1, wr_b = 1, go = 0, dma = 0, ack, le_b, mw_b, done, irq;
	logic [2:0] ev = 3'h0;
	logic [3:0] sel = 4'h0, load = 4'h0;
	logic [15:0] din = 16'h0000, adr = 16'h0000, dout, oe_b;
	int mismatches = 0, comparisons = 0, cyc = 0, lo = 0, mw = 0;
	always #2.5 clk = ~clk;
	// remote write outputs are counted where they are settled
	always @(negedge clk)
	begin
		lo = lo + !le_b;
		mw = mw + !mw_b;
		if (oe_b == 16'h0000)
			adr = dout;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			final_report();
		end
	end
	nic_host_slave_port i_nic_host_slave_port (.core_clk_i(clk), .rst_b_i(rst_b), .rx_done_i(ev[0]),
		.tx_done_i(ev[1]), .dma_done_i(ev[2]), .dma_active_i(dma), .remote_addr_i(16'h5a3c),
		.latch_write_ack_i(ack), .latch_output_enable_b_o(le_b), .mem_write_b_o(mw_b), .remote_write_done_o(done),
		.chip_select_b_i(cs_b), .addr_latch_strobe_i(as), .reg_select_i(sel), .slave_read_strobe_b_i(rd_b),
		.slave_write_strobe_b_i(wr_b), .muxed_addr_data_i(din), .muxed_addr_data_o(dout),
		.muxed_addr_data_oe_b_o(oe_b), .irq_o(irq));
	nic_latch_host i_nic_latch_host (.core_clk_i(clk), .rst_b_i(rst_b), .go_i(go), .load_i(load),
		.done_i(done), .ack_o(ack));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// select changes after the strobe falls, so the latched code must be used
	task acc(input logic [3:0] s, input logic wr, input logic [7:0] d, input logic [7:0] e, input logic cs);
		sel = s;
		din = {8'h00, d};
		cs_b = !cs;
		@(negedge clk) as = 0;
		@(negedge clk) sel = 4'h0;
		wr_b = !wr;
		rd_b = wr;
		repeat (2) @(negedge clk);
		if (!wr) chk(oe_b, (cs && !dma) ? 16'hff00 : 16'hffff);
		if (!wr && cs && !dma) chk({8'h00, dout[7:0]}, {8'h00, e});
		wr_b = 1;
		rd_b = 1;
		@(negedge clk) cs_b = 1;
		as = 1;
		@(negedge clk);
	endtask : acc
	task rwrite(input logic [3:0] l);
		load = l;
		go = 1;
		@(negedge clk) go = 0;
		lo = 0;
		mw = 0;
		adr = 16'h0000;
		for (int i = 0; i < 60 && done !== 1'b1; i++) @(negedge clk);
		chk({15'h0, done}, 16'h0001);
		chk(16'(lo), 16'(WRITE_CYC));
		chk(16'(mw), 16'(WRITE_CYC));
		chk(adr, 16'h5a3c);
		repeat (3) @(negedge clk);
	endtask : rwrite
	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (20) @(negedge clk);
		rst_b = 1;
		chk({oe_b[15:1], irq}, 16'hfffe);
		foreach (rows[i])
		begin
			acc(MASK_SEL, 1, {5'h00, rows[i][3:1]}, 8'h00, 1);
			@(negedge clk) ev = rows[i][6:4];
			@(negedge clk) ev = 3'h0;
			@(negedge clk) chk({15'h0, irq}, {15'h0, rows[i][0]});
			acc(STATUS_SEL, 0, 8'h00, {5'h00, rows[i][6:4]}, 1);
			acc(STATUS_SEL, 1, 8'h07, 8'h00, 1);
			chk({15'h0, irq}, 16'h0000);
		end
		acc(MASK_SEL, 1, 8'h00, 8'h00, 0);
		acc(MASK_SEL, 0, 8'h00, 8'h00, 0);
		acc(MASK_SEL, 0, 8'h00, 8'h02, 1);
		acc(4'h3, 0, 8'h00, 8'h00, 1);
		acc(MASK_SEL, 1, 8'h05, 8'h00, 1);
		dma = 1;
		acc(MASK_SEL, 1, 8'h07, 8'h00, 1);
		acc(MASK_SEL, 0, 8'h00, 8'h00, 1);
		dma = 0;
		acc(MASK_SEL, 0, 8'h00, 8'h05, 1);
		@(negedge clk) ev = 3'h5;
		@(negedge clk) ev = 3'h0;
		acc(STATUS_SEL, 1, 8'h01, 8'h00, 1);
		chk({15'h0, irq}, 16'h0001);
		acc(STATUS_SEL, 1, 8'h04, 8'h00, 1);
		chk({15'h0, irq}, 16'h0000);
		rwrite(4'h0);
		rwrite(4'h5);
		// reset in mid-run clears pending events and the mask
		@(negedge clk) ev = 3'h7;
		@(negedge clk) ev = 3'h0;
		chk({15'h0, irq}, 16'h0001);
		rst_b = 0;
		@(negedge clk) chk({oe_b[15:1], irq}, 16'hfffe);
		rst_b = 1;
		acc(MASK_SEL, 0, 8'h00, 8'h00, 1);
		acc(STATUS_SEL, 0, 8'h00, 8'h00, 1);
		final_report();
	end
endmodule : nic_host_slave_port_tb_top
